// >>> src/mmr_monitor_bank.sv
// read-only monitor readback bank behind an APB slave
// assumes: result strobes come from control logic on pclk; zero-wait APB master
//
// Function
// RL1: rotor speed estimate is a read-only 32-bit fixed-point word, scale 2^27.
// RL2: dc supply current estimate is a read-only 32-bit word, scale 2^27.
// RL3: three read-only 32-bit measured winding currents, one per phase.
// RL4: sense amp gain code reads as 16 bits, codes 0..3 mean x8..x1.
// RL5: voltage range code reads as 16 bits, 0=60V, 1=30V, 2=15V.
// RL6: supply voltage reading is a read-only 32-bit word, scale 60/2^27.
// RL7: phase voltages captured during startup speed detect, read-only 32-bit each.
// RL8: all 32-bit monitor words clear to zero on reset.
// RL9: both 16-bit gain codes reset to zero.
// RL10: rotor speed estimate sits at its own index 196h, reset zero.
// RL11: writes to monitor registers are ignored without error.
// RL12: whole result sets load in one cycle, never a torn word.
`timescale 1ns/1ps
`include "mmr_map.svh"
module mmr_monitor_bank
    import mmr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`MMR_ADDR_W-1:0] paddr,
    input wire logic [`MMR_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [`MMR_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // control algorithm results
    input wire logic loop_result_valid,
    input wire mmr_loop_result_t loop_result,
    input wire logic gain_code_valid,
    input wire mmr_gain_code_t gain_code,
    input wire logic startup_speed_detect,
    input wire logic detect_volt_valid,
    input wire mmr_detect_volt_t detect_volt
);
    localparam int NUM_LOOP = 6;
    localparam int NUM_DET = 3;

    mmr_loop_result_t loop_q;
    mmr_gain_code_t gain_q;
    mmr_detect_volt_t det_q;

    logic det_load;
    logic setup_phase;
    logic [`MMR_IDX_W-1:0] reg_index;
    logic addr_aligned;
    logic hit;
    logic [`MMR_DATA_W-1:0] read_word;
    logic [`MMR_DATA_W-1:0] prdata_q;
    logic pslverr_q;

    // each word of a result set loads on the same edge [RL12]
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LOOP; gi++) begin : g_loop
            mmr_hold_reg #(
                .WIDTH(32)
            ) u_word (
                .pclk(pclk),
                .presetn(presetn), // zero after reset [RL8] [RL10]
                .load(loop_result_valid), // [RL1] [RL2] [RL3] [RL6] [RL12]
                .d(loop_result[gi*32 +: 32]),
                .q(loop_q[gi*32 +: 32])
            );
        end
        for (gi = 0; gi < 2; gi++) begin : g_code
            mmr_hold_reg #(
                .WIDTH(16)
            ) u_code (
                .pclk(pclk),
                .presetn(presetn), // codes reset to x8 gain and 60V range [RL9]
                .load(gain_code_valid), // [RL4] [RL5] [RL12]
                .d(gain_code[gi*16 +: 16]),
                .q(gain_q[gi*16 +: 16])
            );
        end
    endgenerate

    // phase voltages only sampled while startup speed detection runs
    assign det_load = detect_volt_valid & startup_speed_detect; // [RL7]

    generate
        for (gi = 0; gi < NUM_DET; gi++) begin : g_det
            mmr_hold_reg #(
                .WIDTH(32)
            ) u_volt (
                .pclk(pclk),
                .presetn(presetn), // [RL8]
                .load(det_load), // [RL7] [RL12]
                .d(detect_volt[gi*32 +: 32]),
                .q(det_q[gi*32 +: 32])
            );
        end
    endgenerate

    // address decode: byte address is four times the register index
    assign setup_phase = psel & ~penable;
    assign reg_index = paddr[`MMR_ADDR_W-1:2];
    assign addr_aligned = (paddr[1:0] == 2'h0);

    always_comb begin
        read_word = `MMR_RST_WORD;
        hit = addr_aligned;
        case (reg_index)
            `MMR_IDX_ROTOR_SPEED: begin
                read_word = loop_q.rotor_speed_estimate; // [RL1] [RL10]
            end
            `MMR_IDX_DC_CURRENT: begin
                read_word = loop_q.dc_supply_current_estimate; // [RL2]
            end
            `MMR_IDX_WIND_A_CUR: begin
                read_word = loop_q.winding_a_current_measured; // [RL3]
            end
            `MMR_IDX_WIND_B_CUR: begin
                read_word = loop_q.winding_b_current_measured; // [RL3]
            end
            `MMR_IDX_WIND_C_CUR: begin
                read_word = loop_q.winding_c_current_measured; // [RL3]
            end
            `MMR_IDX_AMP_GAIN: begin
                read_word = {16'h0000, gain_q.sense_amp_gain_code}; // [RL4]
            end
            `MMR_IDX_VOLT_RANGE: begin
                read_word = {16'h0000, gain_q.voltage_range_code}; // [RL5]
            end
            `MMR_IDX_SUPPLY_VOLT: begin
                read_word = loop_q.supply_voltage_reading; // [RL6]
            end
            `MMR_IDX_WIND_A_VOLT: begin
                read_word = det_q.winding_a_voltage_snapshot; // [RL7]
            end
            `MMR_IDX_WIND_B_VOLT: begin
                read_word = det_q.winding_b_voltage_snapshot; // [RL7]
            end
            `MMR_IDX_WIND_C_VOLT: begin
                read_word = det_q.winding_c_voltage_snapshot; // [RL7]
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        if (!addr_aligned) begin
            read_word = `MMR_RST_WORD;
        end
    end

    // read data captured in setup, held through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= `MMR_RST_WORD;
        end else if (setup_phase) begin
            prdata_q <= pwrite ? `MMR_RST_WORD : read_word;
        end
    end

    // writes to mapped words are dropped silently; only unmapped or misaligned access errs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_q <= 1'b0;
        end else if (setup_phase) begin
            pslverr_q <= ~hit; // [RL11]
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = pslverr_q & psel & penable;

    // write data and strobes have no destination in a read-only bank
    logic unused_wr;
    assign unused_wr = ^{pwdata, pstrb}; // [RL11]

endmodule // mmr_monitor_bank

// >>> src/mmr_map.svh
// register index map, reset values and bus widths of the monitor readback bank
// assumes: included by its bare name; byte address is four times the index
`ifndef MMR_MAP_SVH
`define MMR_MAP_SVH

`define MMR_ADDR_W 16
`define MMR_DATA_W 32
`define MMR_IDX_W 14

`define MMR_IDX_ROTOR_SPEED 14'h0196
`define MMR_IDX_DC_CURRENT 14'h0410
`define MMR_IDX_WIND_A_CUR 14'h0440
`define MMR_IDX_WIND_B_CUR 14'h0442
`define MMR_IDX_WIND_C_CUR 14'h0444
`define MMR_IDX_AMP_GAIN 14'h0468
`define MMR_IDX_VOLT_RANGE 14'h0472
`define MMR_IDX_SUPPLY_VOLT 14'h0474
`define MMR_IDX_WIND_A_VOLT 14'h047a
`define MMR_IDX_WIND_B_VOLT 14'h047c
`define MMR_IDX_WIND_C_VOLT 14'h047e

`define MMR_RST_WORD 32'h00000000
`define MMR_RST_CODE 16'h0000

// fixed-point scale exponent of every 32-bit reading
`define MMR_FRAC_BITS 27

// gain code values
`define MMR_GAIN_X8 16'h0000
`define MMR_GAIN_X4 16'h0001
`define MMR_GAIN_X2 16'h0002
`define MMR_GAIN_X1 16'h0003

// voltage range codes
`define MMR_RANGE_60V 16'h0000
`define MMR_RANGE_30V 16'h0001
`define MMR_RANGE_15V 16'h0002

`endif

// >>> src/mmr_pkg.sv
// types of the monitor readback bank
// assumes: nothing beyond the map header
package mmr_pkg;

    // one completed control-loop result set
    typedef struct packed {
        logic [31:0] rotor_speed_estimate;
        logic [31:0] dc_supply_current_estimate;
        logic [31:0] winding_a_current_measured;
        logic [31:0] winding_b_current_measured;
        logic [31:0] winding_c_current_measured;
        logic [31:0] supply_voltage_reading;
    } mmr_loop_result_t;

    // gain settings in force
    typedef struct packed {
        logic [15:0] sense_amp_gain_code;
        logic [15:0] voltage_range_code;
    } mmr_gain_code_t;

    // phase voltages sampled during startup speed detection
    typedef struct packed {
        logic [31:0] winding_a_voltage_snapshot;
        logic [31:0] winding_b_voltage_snapshot;
        logic [31:0] winding_c_voltage_snapshot;
    } mmr_detect_volt_t;

endpackage

// >>> src/mmr_hold_reg.sv
// load-enabled holding register of parameterised width
// assumes: pclk domain, asynchronous active-low reset
`timescale 1ns/1ps
module mmr_hold_reg #(
    parameter int WIDTH = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] value_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_q <= '0;
        end else if (load) begin
            value_q <= d;
        end
    end

    assign q = value_q;
endmodule // mmr_hold_reg

// >>> tb/mmr_monitor_checker.sv
// assertions on the apb side of the monitor readback bank
// assumes: bound to the bank from the tb top file
`timescale 1ns/1ps
module mmr_monitor_checker
    import mmr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic loop_result_valid,
    input wire mmr_loop_result_t loop_result
);
    logic acc;
    logic hit;
    assign acc = psel && penable;
    assign hit = paddr inside {16'h0658, 16'h1040, 16'h1100, 16'h1108, 16'h1110,
        16'h11a0, 16'h11c8, 16'h11d0, 16'h11e8, 16'h11f0, 16'h11f8};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_high: assert property (pready) else $error("stall");
    a_idle_noerr: assert property (!acc |-> !pslverr) else $error("idle err");
    a_bad_err: assert property (acc && !hit |-> pslverr) else $error("no err");
    a_good_ok: assert property (acc && hit |-> !pslverr) else $error("err");
    a_wr_zero: assert property (acc && pwrite |-> prdata == 32'h0) else $error("wdata");
    a_err_zero: assert property (acc && pslverr |-> prdata == 32'h0) else $error("edata");
    a_code_top: assert property (acc && paddr inside {16'h11a0, 16'h11c8}
        |-> prdata[31:16] == 16'h0000) else $error("code top");
    a_speed_load: assert property (loop_result_valid ##1 psel && !penable
        && !pwrite && paddr == 16'h0658 ##1 acc
        |-> prdata == $past(loop_result.rotor_speed_estimate, 2)) else $error("speed");
endmodule // mmr_monitor_checker

// >>> tb/tb.sv
// self-checking bench of the monitor readback bank
// assumes: apb master model here, checker bound below
`timescale 1ns/1ps
module tb
    import mmr_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [15:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, er;
    logic loop_result_valid = 0, gain_code_valid = 0;
    logic startup_speed_detect = 0, detect_volt_valid = 0;
    mmr_loop_result_t loop_result = '0;
    mmr_gain_code_t gain_code = '0;
    mmr_detect_volt_t detect_volt = '0;
    int n_mismatch = 0, checked = 0;
    // byte addresses: speed dc ia ib ic gain range vm va vb vc
    localparam logic [15:0] A[11] = '{16'h0658, 16'h1040, 16'h1100, 16'h1108,
        16'h1110, 16'h11a0, 16'h11c8, 16'h11d0, 16'h11e8, 16'h11f0, 16'h11f8};
    localparam logic [31:0] V[6] = '{32'h01234567, 32'h89abcdef, 32'hfedcba98,
        32'h76543210, 32'h0f0f0f0f, 32'hf0f0f00f};
    initial forever #4 pclk = ~pclk;
    mmr_monitor_bank i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .loop_result_valid,
        .loop_result, .gain_code_valid, .gain_code, .startup_speed_detect,
        .detect_volt_valid, .detect_volt);
    task results;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s exp %h got %h", nm, e, g);
        end
    endtask
    task apb(input logic w, input logic [15:0] a);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'h5a5aa5a5;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        // hold the request through any wait states; only the watchdog ends this
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task rdchk(input string nm, input logic [15:0] a, input logic [31:0] e);
        apb(0, a);
        chk(nm, e, rd);
        chk("pslverr", 32'h0, er);
    endtask
    task t_reset;
        for (int i = 0; i < 11; i++) rdchk("reset", A[i], 0);
    endtask
    task t_loop(input logic [31:0] x);
        loop_result <= {V[0] ^ x, V[1] ^ x, V[2] ^ x, V[3] ^ x, V[4] ^ x, V[5] ^ x};
        loop_result_valid <= 1;
        @(posedge pclk);
        loop_result_valid <= 0;
        for (int i = 0; i < 6; i++) rdchk("loop", A[i < 5 ? i : 7], V[i] ^ x);
    endtask
    task t_gain;
        for (int c = 0; c < 4; c++) begin
            gain_code <= {16'(c), 16'(c < 3 ? c : 2)};
            gain_code_valid <= 1;
            @(posedge pclk);
            gain_code_valid <= 0;
            rdchk("gain", A[5], c);
            rdchk("range", A[6], c < 3 ? c : 2);
        end
    endtask
    task t_detect(input logic s, input logic [31:0] e);
        detect_volt <= {32'h0a1a1a1a, 32'h0b2b2b2b, 32'h0c3c3c3c};
        detect_volt_valid <= 1;
        startup_speed_detect <= s;
        @(posedge pclk);
        detect_volt_valid <= 0;
        startup_speed_detect <= 0;
        rdchk("va", A[8], e & 32'h0a1a1a1a);
        rdchk("vb", A[9], e & 32'h0b2b2b2b);
        rdchk("vc", A[10], e & 32'h0c3c3c3c);
    endtask
    task t_write;
        apb(1, A[0]);
        chk("wr err", 32'h0, er);
        rdchk("speed", A[0], ~V[0]);
        apb(0, 16'h0654);
        chk("bad err", 32'h1, er);
        chk("bad data", 32'h0, rd);
        apb(0, 16'h0659);
        chk("odd err", 32'h1, er);
        apb(1, 16'h0654);
        chk("bad wr err", 32'h1, er);
        chk("bad wr data", 32'h0, rd);
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_reset;
        t_loop(0);
        t_loop(32'hffffffff);
        t_gain;
        t_detect(0, 0);
        t_detect(1, 32'hffffffff);
        t_write;
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_reset;
        results;
    end
    initial begin
        #100000;
        n_mismatch++;
        results;
    end
endmodule // tb
bind mmr_monitor_bank mmr_monitor_checker i_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .loop_result_valid, .loop_result);
